// ### fpcs_pkg.sv
`default_nettype none
package fpcs_pkg;

  // register word indices; byte address is four times the index
  localparam logic [5:0] FPCS_CFG_IDX = 6'h16;
  localparam logic [5:0] FPCS_STAT_IDX = 6'h17;

  // bit positions of the configuration word
  localparam int FPCS_POLICY_BIT = 8;
  localparam int FPCS_TMO_SEL_BIT = 7;
  localparam int FPCS_FIBER_BIT = 6;
  localparam int FPCS_FORCE_BIT = 5;
  localparam int FPCS_RSVD_BIT = 4;
  localparam int FPCS_FAR_FAULT_BIT = 3;
  localparam int FPCS_TRANS_BIT = 2;
  localparam int FPCS_WHITEN_BIT = 1;
  localparam int FPCS_DEWHITEN_BIT = 0;

  // bit positions of the status word
  localparam int FPCS_ST_LINK_BIT = 0;
  localparam int FPCS_ST_LOCK_BIT = 1;
  localparam int FPCS_ST_FORCE_BIT = 2;
  localparam int FPCS_ST_STRAP_BIT = 3;
  localparam int FPCS_ST_SIGNAL_BIT = 4;

  // descrambler timeouts
  localparam int unsigned FPCS_CLK_PERIOD_NS = 20;
  localparam int unsigned FPCS_TMO_SHORT_US = 722;
  localparam int unsigned FPCS_TMO_LONG_MS = 2;
  localparam int unsigned FPCS_TMO_SHORT_CYC = FPCS_TMO_SHORT_US * 1000 / FPCS_CLK_PERIOD_NS;
  localparam int unsigned FPCS_TMO_LONG_CYC = FPCS_TMO_LONG_MS * 1000000 / FPCS_CLK_PERIOD_NS;
  localparam int FPCS_TMO_W = 17;

  typedef struct packed {
    logic link_hold_policy;
    logic descrambler_timeout_select;
    logic fiber_mode_enable;
    logic force_good_link;
    logic far_fault_indication_enable;
    logic transition_bypass;
    logic whitening_skip;
    logic dewhitening_skip;
  } fpcs_cfg_t;

  localparam fpcs_cfg_t FPCS_CFG_RST = '{
    link_hold_policy: 1'b1,
    default: 1'b0
  };

  // packs the configuration into its 16-bit register image
  function automatic logic [15:0] fpcs_cfg_word(input fpcs_cfg_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[FPCS_POLICY_BIT] = c.link_hold_policy;
    w[FPCS_TMO_SEL_BIT] = c.descrambler_timeout_select;
    w[FPCS_FIBER_BIT] = c.fiber_mode_enable;
    w[FPCS_FORCE_BIT] = c.force_good_link;
    w[FPCS_FAR_FAULT_BIT] = c.far_fault_indication_enable;
    w[FPCS_TRANS_BIT] = c.transition_bypass;
    w[FPCS_WHITEN_BIT] = c.whitening_skip;
    w[FPCS_DEWHITEN_BIT] = c.dewhitening_skip;
    return w;
  endfunction

endpackage
`default_nettype wire

// ### fpcs_desc_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fpcs_desc_timer
  import fpcs_pkg::*;
#(
  parameter int unsigned SHORT_CYC = FPCS_TMO_SHORT_CYC,
  parameter int unsigned LONG_CYC = FPCS_TMO_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sync_seen_i,
  input wire logic long_sel_i,
  input wire logic bypass_i,
  output logic lock_o
);

  logic [FPCS_TMO_W-1:0] cnt_q;
  logic [FPCS_TMO_W-1:0] limit;
  logic lock_q;

  assign limit = long_sel_i ? FPCS_TMO_W'(LONG_CYC - 1) : FPCS_TMO_W'(SHORT_CYC - 1);
  assign lock_o = lock_q;

  // silence counter since the last sync pattern
  always_ff @(posedge clk_i) begin
    if (rst_i || bypass_i || sync_seen_i || !lock_q) begin
      cnt_q <= '0;
    end else if (cnt_q == limit) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // lock drops after the selected timeout of silence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else if (bypass_i || sync_seen_i) begin
      lock_q <= 1'b1;
    end else if (lock_q && cnt_q == limit) begin
      lock_q <= 1'b0;
    end
  end

  property p_tmo_len;
    @(posedge clk_i) disable iff (rst_i)
    $fell(lock_q) |-> $past(cnt_q) == (($past(long_sel_i)) ?
      FPCS_TMO_W'(LONG_CYC - 1) : FPCS_TMO_W'(SHORT_CYC - 1));
  endproperty
  a_tmo_len: assert property (p_tmo_len) else $error("timeout length wrong");

endmodule
`default_nettype wire

// ### fpcs_link_qual.sv
`timescale 1ns/100ps
`default_nettype none
module fpcs_link_qual
  import fpcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_policy_i,
  input wire logic signal_valid_i,
  input wire logic lock_i,
  output logic up_o
);

  typedef enum logic {FPCS_DOWN, FPCS_UP} fpcs_link_st_t;
  fpcs_link_st_t state_q;
  fpcs_link_st_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      FPCS_DOWN: begin
        if (signal_valid_i && lock_i) begin
          state_d = FPCS_UP;
        end
      end
      FPCS_UP: begin
        if (!signal_valid_i) begin
          state_d = FPCS_DOWN;
        end else if (!hold_policy_i && !lock_i) begin
          state_d = FPCS_DOWN;
        end
      end
      default: state_d = FPCS_DOWN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= FPCS_DOWN;
    end else begin
      state_q <= state_d;
    end
  end

  assign up_o = (state_q == FPCS_UP);

endmodule
`default_nettype wire

// ### fpcs_cfg_top.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fpcs_cfg_top
  import fpcs_pkg::*;
#(
  parameter int unsigned SHORT_TMO_CYC = FPCS_TMO_SHORT_CYC,
  parameter int unsigned LONG_TMO_CYC = FPCS_TMO_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fiber_strap_i,
  input wire logic external_force_link_input_i,
  input wire logic signal_valid_i,
  input wire logic descrambler_sync_i,
  output logic link_up_o,
  output logic descrambler_lock_o,
  output logic force_good_link_o,
  output logic fiber_mode_enable_o,
  output logic far_fault_indication_enable_o,
  output logic transition_bypass_o,
  output logic whitening_skip_o,
  output logic dewhitening_skip_o,
  output logic descrambler_timeout_select_o
);

  fpcs_cfg_t cfg_q;
  logic strap_pend_q;
  logic strap_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic link_q;
  logic force_q;
  logic lock;
  logic qual_up;
  logic req_take;
  logic [5:0] idx;
  logic cfg_wr;
  logic [15:0] stat_word;

  assign idx = wb_adr_i[7:2];
  assign req_take = wb_cyc_i && wb_stb_i && !ack_q;
  assign cfg_wr = req_take && wb_we_i && idx == FPCS_CFG_IDX;

  // strap capture on the first clock after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_pend_q <= 1'b1;
    end else begin
      strap_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_q <= 1'b0;
    end else if (strap_pend_q) begin
      strap_q <= fiber_strap_i;
    end
  end

  // configuration word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= FPCS_CFG_RST;
    end else if (strap_pend_q) begin
      cfg_q.fiber_mode_enable <= fiber_strap_i;
      cfg_q.far_fault_indication_enable <= fiber_strap_i;
      cfg_q.whitening_skip <= fiber_strap_i;
      cfg_q.dewhitening_skip <= fiber_strap_i;
    end else if (cfg_wr) begin
      if (wb_sel_i[1]) begin
        cfg_q.link_hold_policy <= wb_dat_i[FPCS_POLICY_BIT];
      end
      if (wb_sel_i[0]) begin
        cfg_q.descrambler_timeout_select <= wb_dat_i[FPCS_TMO_SEL_BIT];
        cfg_q.fiber_mode_enable <= wb_dat_i[FPCS_FIBER_BIT];
        cfg_q.force_good_link <= wb_dat_i[FPCS_FORCE_BIT];
        cfg_q.far_fault_indication_enable <= wb_dat_i[FPCS_FAR_FAULT_BIT];
        cfg_q.transition_bypass <= wb_dat_i[FPCS_TRANS_BIT];
        cfg_q.whitening_skip <= wb_dat_i[FPCS_WHITEN_BIT];
        cfg_q.dewhitening_skip <= wb_dat_i[FPCS_DEWHITEN_BIT];
      end
    end
  end

  // status image
  always_comb begin
    stat_word = 16'h0000;
    stat_word[FPCS_ST_LINK_BIT] = link_q;
    stat_word[FPCS_ST_LOCK_BIT] = lock;
    stat_word[FPCS_ST_FORCE_BIT] = force_q;
    stat_word[FPCS_ST_STRAP_BIT] = strap_q;
    stat_word[FPCS_ST_SIGNAL_BIT] = signal_valid_i;
  end

  // wishbone answer, one cycle after the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_take;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req_take && !wb_we_i) begin
      case (idx)
        FPCS_CFG_IDX: dat_q <= {16'h0000, fpcs_cfg_word(cfg_q)};
        FPCS_STAT_IDX: dat_q <= {16'h0000, stat_word};
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // descrambler lock tracking
  fpcs_desc_timer #(
    .SHORT_CYC(SHORT_TMO_CYC),
    .LONG_CYC(LONG_TMO_CYC)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sync_seen_i(descrambler_sync_i),
    .long_sel_i(cfg_q.descrambler_timeout_select),
    .bypass_i(cfg_q.dewhitening_skip),
    .lock_o(lock)
  );

  // link qualification
  fpcs_link_qual u_qual (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .hold_policy_i(cfg_q.link_hold_policy),
    .signal_valid_i(signal_valid_i),
    .lock_i(lock),
    .up_o(qual_up)
  );

  // forced link overrides the qualified state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_q <= 1'b0;
    end else begin
      force_q <= cfg_q.force_good_link | external_force_link_input_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_q <= 1'b0;
    end else begin
      link_q <= qual_up | cfg_q.force_good_link | external_force_link_input_i;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign link_up_o = link_q;
  assign descrambler_lock_o = lock;
  assign force_good_link_o = force_q;
  assign fiber_mode_enable_o = cfg_q.fiber_mode_enable;
  assign far_fault_indication_enable_o = cfg_q.far_fault_indication_enable;
  assign transition_bypass_o = cfg_q.transition_bypass;
  assign whitening_skip_o = cfg_q.whitening_skip;
  assign dewhitening_skip_o = cfg_q.dewhitening_skip;
  assign descrambler_timeout_select_o = cfg_q.descrambler_timeout_select;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_hold_keep;
    cfg_q.link_hold_policy && qual_up && signal_valid_i && !lock
      |=> qual_up ##1 link_q;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("held link dropped");

  property p_strict_drop;
    !cfg_q.link_hold_policy && qual_up && (!signal_valid_i || !lock) && !force_q
      && !cfg_q.force_good_link && !external_force_link_input_i
      |=> !qual_up ##1 (!link_q || $past(cfg_q.force_good_link)
        || $past(external_force_link_input_i));
  endproperty
  a_strict_drop: assert property (p_strict_drop) else $error("link not dropped");

  property p_rise;
    !qual_up && signal_valid_i && lock |=> qual_up;
  endproperty
  a_rise: assert property (p_rise) else $error("link not raised");

  property p_tmo_sel;
    cfg_wr && wb_sel_i[0] && !strap_pend_q
      |=> descrambler_timeout_select_o == $past(wb_dat_i[FPCS_TMO_SEL_BIT]);
  endproperty
  a_tmo_sel: assert property (p_tmo_sel) else $error("timeout select not stored");

  property p_fiber_strap;
    $fell(strap_pend_q) |-> fiber_mode_enable_o == $past(fiber_strap_i);
  endproperty
  a_fiber_strap: assert property (p_fiber_strap) else $error("fiber strap lost");

  property p_force;
    cfg_q.force_good_link || external_force_link_input_i |=> link_up_o && force_good_link_o;
  endproperty
  a_force: assert property (p_force) else $error("forced link absent");

  property p_rsvd;
    wb_ack_o && !$past(wb_we_i) && $past(idx) == FPCS_CFG_IDX |-> wb_dat_o[FPCS_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");

  property p_far_strap;
    $fell(strap_pend_q) |-> far_fault_indication_enable_o == $past(fiber_strap_i);
  endproperty
  a_far_strap: assert property (p_far_strap) else $error("far fault strap lost");

  property p_trans_wr;
    cfg_wr && wb_sel_i[0] && !strap_pend_q
      |=> transition_bypass_o == $past(wb_dat_i[FPCS_TRANS_BIT]) ##1 wb_ack_o == 1'b0;
  endproperty
  a_trans_wr: assert property (p_trans_wr) else $error("bypass write lost");

  property p_whiten_strap;
    $fell(strap_pend_q) |-> whitening_skip_o == $past(fiber_strap_i);
  endproperty
  a_whiten_strap: assert property (p_whiten_strap) else $error("whitening strap lost");

  property p_dewhiten_strap;
    $fell(strap_pend_q) |-> dewhitening_skip_o == $past(fiber_strap_i)
      ##1 (descrambler_lock_o || !$past(dewhitening_skip_o));
  endproperty
  a_dewhiten_strap: assert property (p_dewhiten_strap) else $error("dewhite strap");

  property p_strap_rw;
    cfg_wr && wb_sel_i[0] && !strap_pend_q
      |=> fiber_mode_enable_o == $past(wb_dat_i[FPCS_FIBER_BIT]);
  endproperty
  a_strap_rw: assert property (p_strap_rw) else $error("strapped bit not writable");

  // power-up values, link holding and bit retention
  property p_policy_rst;
    $fell(strap_pend_q) |-> cfg_q.link_hold_policy;
  endproperty
  a_policy_rst: assert property (p_policy_rst) else $error("policy reset");

  property p_hold_sig;
    cfg_q.link_hold_policy && qual_up && signal_valid_i |=> qual_up;
  endproperty
  a_hold_sig: assert property (p_hold_sig) else $error("held link lost");

  property p_sig_loss;
    qual_up && !signal_valid_i |=> !qual_up;
  endproperty
  a_sig_loss: assert property (p_sig_loss) else $error("link without signal");

  property p_strict_keep;
    !cfg_q.link_hold_policy && qual_up && signal_valid_i && lock |=> qual_up;
  endproperty
  a_strict_keep: assert property (p_strict_keep) else $error("strict link lost");

  property p_tmo_rst;
    $fell(strap_pend_q) |-> !descrambler_timeout_select_o;
  endproperty
  a_tmo_rst: assert property (p_tmo_rst) else $error("timeout reset");

  property p_sync_lock;
    descrambler_sync_i |=> descrambler_lock_o;
  endproperty
  a_sync_lock: assert property (p_sync_lock) else $error("no lock after sync");

  property p_fiber_keep;
    !strap_pend_q && !cfg_wr |=> $stable(fiber_mode_enable_o);
  endproperty
  a_fiber_keep: assert property (p_fiber_keep) else $error("fiber bit changed");

  property p_force_rst;
    $fell(strap_pend_q) |-> !cfg_q.force_good_link;
  endproperty
  a_force_rst: assert property (p_force_rst) else $error("force reset");

  property p_force_off;
    !cfg_q.force_good_link && !external_force_link_input_i |=> !force_good_link_o;
  endproperty
  a_force_off: assert property (p_force_off) else $error("force without cause");

  property p_cfg_upper;
    wb_ack_o && !$past(wb_we_i) && $past(idx) == FPCS_CFG_IDX |-> wb_dat_o[31:9] == '0;
  endproperty
  a_cfg_upper: assert property (p_cfg_upper) else $error("unused bits read one");

  property p_unmapped_rd;
    wb_ack_o && !$past(wb_we_i) && $past(idx) != FPCS_CFG_IDX && $past(idx) != FPCS_STAT_IDX
      |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read");

  property p_far_keep;
    !strap_pend_q && !cfg_wr |=> $stable(far_fault_indication_enable_o);
  endproperty
  a_far_keep: assert property (p_far_keep) else $error("far fault changed");

  property p_trans_rst;
    $fell(strap_pend_q) |-> !transition_bypass_o;
  endproperty
  a_trans_rst: assert property (p_trans_rst) else $error("bypass reset");

  property p_whiten_keep;
    !strap_pend_q && !cfg_wr |=> $stable(whitening_skip_o);
  endproperty
  a_whiten_keep: assert property (p_whiten_keep) else $error("whitening changed");

  property p_bypass_lock;
    dewhitening_skip_o |=> descrambler_lock_o;
  endproperty
  a_bypass_lock: assert property (p_bypass_lock) else $error("bypass lock");

  property p_strap_load;
    $fell(strap_pend_q) |-> strap_q == $past(fiber_strap_i);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not captured");

  property p_strap_hold;
    !strap_pend_q |=> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap recaptured");

endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import fpcs_pkg::*;
  localparam int SH = 20;
  localparam int LG = 50;
  localparam logic [7:0] CFG = 8'h58;
  localparam logic [7:0] STA = 8'h5c;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic strap = 1'b1;
  logic ext = 1'b0;
  logic sig = 1'b0;
  logic sync = 1'b0;
  logic link_up_o, lock_o, force_o, fiber_o, far_o, trans_o, wh_o, dewh_o, tmo_o;
  int n_fail = 0;
  int checks = 0;
  int seed = 32'hff51;
  logic [31:0] exp_q[$];

  always #10 clk_i = ~clk_i;

  fpcs_cfg_top #(.SHORT_TMO_CYC(SH), .LONG_TMO_CYC(LG)) i_fpcs_cfg_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fiber_strap_i(strap),
    .external_force_link_input_i(ext), .signal_valid_i(sig),
    .descrambler_sync_i(sync), .link_up_o(link_up_o), .descrambler_lock_o(lock_o),
    .force_good_link_o(force_o), .fiber_mode_enable_o(fiber_o),
    .far_fault_indication_enable_o(far_o), .transition_bypass_o(trans_o),
    .whitening_skip_o(wh_o), .dewhitening_skip_o(dewh_o),
    .descrambler_timeout_select_o(tmo_o));

  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  // read data compared when the answer arrives
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
      if (exp_q.size() == 0) begin
        chk("wb_dat_o queue", 32'h1, 32'h0);
      end else begin
        chk("wb_dat_o", exp_q.pop_front(), wb_dat_o);
      end
    end
  end

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      chk_bit("wb_ack_o", 1'b1, wb_ack_o);
      complete_run();
    end else begin
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    bus(1'b1, a, {16'hffff, d}, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0, e});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic do_reset(input logic s);
    strap <= s;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic sync_n(input int n);
    repeat (n) begin
      sync <= 1'b1;
      @(posedge clk_i);
      sync <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  initial begin
    logic [31:0] r;
    do_reset(1'b1);
    rd(CFG, 16'h014b);
    chk_bit("fiber_o", 1'b1, fiber_o);
    rd(STA, 16'h000a);
    wr(CFG, 16'h0000, 4'hf);
    rd(CFG, 16'h0000);
    do_reset(1'b0);
    rd(CFG, 16'h0100);
    wr(CFG, 16'hffff, 4'hf);
    chk("cfg outs", 32'h1f, {27'h0, fiber_o, far_o, trans_o, wh_o, dewh_o});
    rd(CFG, 16'h01ef);
    wr(CFG, 16'h0000, 4'h1);
    rd(CFG, 16'h0100);
    rd(8'h00, 16'h0000);
    wr(8'h04, 16'hffff, 4'hf);
    rd(CFG, 16'h0100);
    repeat (6) begin
      r = $random(seed);
      wr(CFG, r[15:0], 4'h3);
      rd(CFG, r[15:0] & 16'h01ef);
    end
    wr(CFG, 16'h0100, 4'hf);
    // held link survives loss of lock
    sig <= 1'b1;
    sync_n(3);
    wait_cyc(3);
    chk_bit("link_up_o", 1'b1, link_up_o);
    chk_bit("lock_o", 1'b1, lock_o);
    wait_cyc(SH + 5);
    chk_bit("lock_o", 1'b0, lock_o);
    chk_bit("link_up_o", 1'b1, link_up_o);
    sig <= 1'b0;
    wait_cyc(4);
    chk_bit("link_up_o", 1'b0, link_up_o);
    // short and long timeouts
    sync_n(1);
    wait_cyc(SH - 6);
    chk_bit("lock_o", 1'b1, lock_o);
    wait_cyc(10);
    chk_bit("lock_o", 1'b0, lock_o);
    wr(CFG, 16'h0180, 4'hf);
    chk_bit("tmo_o", 1'b1, tmo_o);
    sync_n(1);
    wait_cyc(SH + 5);
    chk_bit("lock_o", 1'b1, lock_o);
    wait_cyc(LG);
    chk_bit("lock_o", 1'b0, lock_o);
    // strict policy drops link with lock
    wr(CFG, 16'h0000, 4'hf);
    sig <= 1'b1;
    sync_n(3);
    wait_cyc(3);
    chk_bit("link_up_o", 1'b1, link_up_o);
    wait_cyc(SH + 5);
    chk_bit("link_up_o", 1'b0, link_up_o);
    sig <= 1'b0;
    // forcing from pin and from bit
    ext <= 1'b1;
    wait_cyc(3);
    chk_bit("force_o", 1'b1, force_o);
    chk_bit("link_up_o", 1'b1, link_up_o);
    ext <= 1'b0;
    wait_cyc(3);
    chk_bit("force_o", 1'b0, force_o);
    wr(CFG, 16'h0020, 4'hf);
    wait_cyc(3);
    chk_bit("link_up_o", 1'b1, link_up_o);
    rd(STA, 16'h0005);
    wait_cyc(3);
    chk("exp_q size", 32'h0, exp_q.size());
    complete_run();
  end
endmodule
`default_nettype wire
